// [rtl/port_pin_ctrl.sv]
// Port pin control: direction, pulls, alternate routing and reset pin over Wishbone
//
// How it works
// - Port 0 six pins, per-bit direction
// - Per-bit pull enable, per-port polarity on ports 0 and A
// - Reset: all inputs, pulls off; port settings clear on resetn only, not on a reset pin reset
// - Port 2 seven pins, pull-up only
// - Reset pin low resets, then settle
// - Writing 0 drives reset pin low
// - Reset bit input only, open-drain low
// - Strap high enables auto reset
// - Port A eight bits, shared functions
// - Port 8 bits 0-5, motor timer alternate
// - Port 2 bits 5-6 double as oscillator
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
module port_pin_ctrl
   import port_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
) (
   input  wire logic            ref_clk,
   input  wire logic            resetn,
   // Wishbone classic slave
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic      [31:0]     wb_dat_o,
   output logic                 wb_ack_o,
   // Pins
   input  wire logic [P0_W-1:0] p0_i,
   output p0_pins_s             p0_pins,
   input  wire logic [P2_W-1:0] p2_i,
   output p2_pins_s             p2_pins,
   input  wire logic [P8_W-1:0] p8_i,
   output p8_pins_s             p8_pins,
   input  wire logic [PA_W-1:0] pa_i,
   output pa_pins_s             pa_pins,
   input  wire logic            reset_pin_low_i,
   output logic                 reset_pin_low_o,
   output logic                 reset_pin_low_oe,
   input  wire logic            auto_reset_strap,
   // Shared peripheral functions
   input  wire logic [P8_W-1:0] motor_timer_output,
   input  wire logic [PA_W-1:0] porta_alt_o,
   input  wire logic [PA_W-1:0] porta_alt_oe,
   input  wire logic            fast_osc_en,
   output logic                 fast_osc_in,
   output logic                 auto_reset_en,
   output logic                 chip_reset,
   output logic                 reset_vector_req
);

   ////////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers
   logic [1:0]      rst_sync_q;
   logic            rst_n;
   logic [P0_W-1:0] p0_m_q, p0_s_q;
   logic [P2_W-1:0] p2_m_q, p2_s_q;
   logic [P8_W-1:0] p8_m_q, p8_s_q;
   logic [PA_W-1:0] pa_m_q, pa_s_q;
   logic [1:0]      misc_m_q, misc_s_q;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         p0_m_q   <= '0;
         p0_s_q   <= '0;
         p2_m_q   <= '0;
         p2_s_q   <= '0;
         p8_m_q   <= '0;
         p8_s_q   <= '0;
         pa_m_q   <= '0;
         pa_s_q   <= '0;
         misc_m_q <= 2'h0;
         misc_s_q <= 2'h0;
      end else begin
         p0_m_q   <= p0_i;
         p0_s_q   <= p0_m_q;
         p2_m_q   <= p2_i;
         p2_s_q   <= p2_m_q;
         p8_m_q   <= p8_i;
         p8_s_q   <= p8_m_q;
         pa_m_q   <= pa_i;
         pa_s_q   <= pa_m_q;
         misc_m_q <= {auto_reset_strap, reset_pin_low_i};
         misc_s_q <= misc_m_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file
   logic [7:0] p0_dir_q, p0_dir_d, p0_pull_q, p0_pull_d, p0_out_q, p0_out_d;
   logic [7:0] p2_dir_q, p2_dir_d, p2_pull_q, p2_pull_d, p2_out_q, p2_out_d;
   logic [7:0] p8_dir_q, p8_dir_d, p8_pull_q, p8_pull_d, p8_out_q, p8_out_d;
   logic [7:0] pa_dir_q, pa_dir_d, pa_pull_q, pa_pull_d, pa_out_q, pa_out_d;
   logic [1:0] pol_q, pol_d, alt_q, alt_d;
   logic       ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic       sw_reset;
   logic       wr;

   // Byte lane 0 merge; fields live in the low byte
   function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel, input logic [31:0] d);
      lane0 = sel[0] ? d[7:0] : old;
   endfunction : lane0

   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

   // Pulls act on inputs only; one polarity bit serves the whole port
   function automatic logic [7:0] pull_of(input logic [7:0] en, input logic [7:0] oe, input logic want);
      pull_of = want ? (en & ~oe) : 8'h00;
   endfunction : pull_of

   always_comb begin
      p0_dir_d  = p0_dir_q;
      p0_pull_d = p0_pull_q;
      p0_out_d  = p0_out_q;
      p2_dir_d  = p2_dir_q;
      p2_pull_d = p2_pull_q;
      p2_out_d  = p2_out_q;
      p8_dir_d  = p8_dir_q;
      p8_pull_d = p8_pull_q;
      p8_out_d  = p8_out_q;
      pa_dir_d  = pa_dir_q;
      pa_pull_d = pa_pull_q;
      pa_out_d  = pa_out_q;
      pol_d     = pol_q;
      alt_d     = alt_q;
      sw_reset  = 1'b0;
      ack_d     = wb_cyc_i && wb_stb_i && !ack_q;
      rdata_d   = UNMAP_DATA;
      if (wr) begin
         case (wb_adr_i)
            P0_DIR_ADDR:   p0_dir_d  = lane0(p0_dir_q, wb_sel_i, wb_dat_i) & 8'h3f;
            P0_PULL_ADDR:  p0_pull_d = lane0(p0_pull_q, wb_sel_i, wb_dat_i) & 8'h3f;
            POL_SEL_ADDR:  pol_d     = wb_sel_i[0] ? wb_dat_i[1:0] : pol_q;
            P2_DIR_ADDR:   p2_dir_d  = lane0(p2_dir_q, wb_sel_i, wb_dat_i) & 8'h7f;
            P2_PULL_ADDR:  p2_pull_d = lane0(p2_pull_q, wb_sel_i, wb_dat_i) & 8'h7f;
            P8_DIR_ADDR:   p8_dir_d  = lane0(p8_dir_q, wb_sel_i, wb_dat_i) & 8'h3f;
            P8_PULL_ADDR:  p8_pull_d = lane0(p8_pull_q, wb_sel_i, wb_dat_i) & 8'h3f;
            PA_DIR_ADDR:   pa_dir_d  = lane0(pa_dir_q, wb_sel_i, wb_dat_i);
            PA_PULL_ADDR:  pa_pull_d = lane0(pa_pull_q, wb_sel_i, wb_dat_i);
            P0_OUT_ADDR:   p0_out_d  = lane0(p0_out_q, wb_sel_i, wb_dat_i) & 8'h3f;
            P2_OUT_ADDR:   p2_out_d  = lane0(p2_out_q, wb_sel_i, wb_dat_i) & 8'h7f;
            P8_OUT_ADDR:   p8_out_d  = lane0(p8_out_q, wb_sel_i, wb_dat_i) & 8'h3f;
            PA_OUT_ADDR:   pa_out_d  = lane0(pa_out_q, wb_sel_i, wb_dat_i);
            ALT_SEL_ADDR:  alt_d     = wb_sel_i[0] ? wb_dat_i[1:0] : alt_q;
            // Writing 0 to the reset port bit starts a software reset
            RST_CTRL_ADDR: sw_reset  = wb_sel_i[0] && !wb_dat_i[0];
            default:       sw_reset  = 1'b0;
         endcase
      end
      case (wb_adr_i)
         P0_DIR_ADDR:   rdata_d = {24'h0, p0_dir_q};
         P0_PULL_ADDR:  rdata_d = {24'h0, p0_pull_q};
         POL_SEL_ADDR:  rdata_d = {30'h0, pol_q};
         P2_DIR_ADDR:   rdata_d = {24'h0, p2_dir_q};
         P2_PULL_ADDR:  rdata_d = {24'h0, p2_pull_q};
         P8_DIR_ADDR:   rdata_d = {24'h0, p8_dir_q};
         P8_PULL_ADDR:  rdata_d = {24'h0, p8_pull_q};
         PA_DIR_ADDR:   rdata_d = {24'h0, pa_dir_q};
         PA_PULL_ADDR:  rdata_d = {24'h0, pa_pull_q};
         P0_OUT_ADDR:   rdata_d = {24'h0, p0_out_q};
         P2_OUT_ADDR:   rdata_d = {24'h0, p2_out_q};
         P8_OUT_ADDR:   rdata_d = {24'h0, p8_out_q};
         PA_OUT_ADDR:   rdata_d = {24'h0, pa_out_q};
         ALT_SEL_ADDR:  rdata_d = {30'h0, alt_q};
         P0_IN_ADDR:    rdata_d = {26'h0, p0_s_q};
         P2_IN_ADDR:    rdata_d = {25'h0, p2_s_q};
         P8_IN_ADDR:    rdata_d = {26'h0, p8_s_q};
         PA_IN_ADDR:    rdata_d = {24'h0, pa_s_q};
         RST_CTRL_ADDR: rdata_d = {31'h0, misc_s_q[0]};
         RST_STAT_ADDR: rdata_d = {30'h0, misc_s_q[0], auto_reset_en};
         default:       rdata_d = UNMAP_DATA;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         p0_dir_q  <= DIR_RST;
         p0_pull_q <= PULL_RST;
         p0_out_q  <= OUT_RST;
         p2_dir_q  <= DIR_RST;
         p2_pull_q <= PULL_RST;
         p2_out_q  <= OUT_RST;
         p8_dir_q  <= DIR_RST;
         p8_pull_q <= PULL_RST;
         p8_out_q  <= OUT_RST;
         pa_dir_q  <= DIR_RST;
         pa_pull_q <= PULL_RST;
         pa_out_q  <= OUT_RST;
         pol_q     <= POL_RST;
         alt_q     <= ALT_RST;
         ack_q     <= 1'b0;
         rdata_q   <= UNMAP_DATA;
      end else begin
         p0_dir_q  <= p0_dir_d;
         p0_pull_q <= p0_pull_d;
         p0_out_q  <= p0_out_d;
         p2_dir_q  <= p2_dir_d;
         p2_pull_q <= p2_pull_d;
         p2_out_q  <= p2_out_d;
         p8_dir_q  <= p8_dir_d;
         p8_pull_q <= p8_pull_d;
         p8_out_q  <= p8_out_d;
         pa_dir_q  <= pa_dir_d;
         pa_pull_q <= pa_pull_d;
         pa_out_q  <= pa_out_d;
         pol_q     <= pol_d;
         alt_q     <= alt_d;
         ack_q     <= ack_d;
         rdata_q   <= rdata_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Auto reset strap, caught after reset release
   logic       strap_q, strap_d;
   logic [1:0] strap_cnt_q, strap_cnt_d;

   always_comb begin
      // Synchroniser shows its reset value for two edges, so catch the strap after them
      strap_cnt_d = (strap_cnt_q == 2'h3) ? strap_cnt_q : strap_cnt_q + 2'h1;
      strap_d     = (strap_cnt_q == 2'h2) ? misc_s_q[1] : strap_q;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_q     <= 1'b0;
         strap_cnt_q <= 2'h0;
      end else begin
         strap_q     <= strap_d;
         strap_cnt_q <= strap_cnt_d;
      end
   end
   assign auto_reset_en = strap_q;

   ////////////////////////////////////////////////////////////////////////
   // Pin drive; pulls only act on inputs
   always_comb begin
      p0_pins.oe = p0_dir_q[P0_W-1:0];
      p0_pins.o  = p0_out_q[P0_W-1:0];
      // One polarity per port, so up and down never mix
      p0_pins.pu = P0_W'(pull_of(p0_pull_q, p0_dir_q, ~pol_q[POL_P0_BIT]));
      p0_pins.pd = P0_W'(pull_of(p0_pull_q, p0_dir_q, pol_q[POL_P0_BIT]));

      p2_pins.oe = p2_dir_q[P2_W-1:0];
      p2_pins.o  = p2_out_q[P2_W-1:0];
      p2_pins.pu = p2_pull_q[P2_W-1:0] & ~p2_dir_q[P2_W-1:0];
      // Oscillator owns bits 5 and 6 while enabled
      if (fast_osc_en) begin
         p2_pins.oe[6:5] = 2'h0;
         p2_pins.pu[6:5] = 2'h0;
      end

      p8_pins.oe = p8_dir_q[P8_W-1:0];
      p8_pins.o  = alt_q[ALT_P8_BIT] ? motor_timer_output : p8_out_q[P8_W-1:0];
      p8_pins.pu = p8_pull_q[P8_W-1:0] & ~p8_dir_q[P8_W-1:0];

      pa_pins.oe = alt_q[ALT_PA_BIT] ? porta_alt_oe : pa_dir_q;
      pa_pins.o  = alt_q[ALT_PA_BIT] ? porta_alt_o : pa_out_q;
      pa_pins.pu = pull_of(pa_pull_q, pa_pins.oe, ~pol_q[POL_PA_BIT]);
      pa_pins.pd = pull_of(pa_pull_q, pa_pins.oe, pol_q[POL_PA_BIT]);
   end

   assign fast_osc_in = p2_s_q[5];

   ////////////////////////////////////////////////////////////////////////
   reset_pin_ctrl #(
      .SETTLE (SETTLE)
   ) u_reset_pin (
      .ref_clk          (ref_clk),
      .rst_n_sync       (rst_n),
      .pin_level        (misc_s_q[0]),
      .sw_reset         (sw_reset),
      .pin_oe           (reset_pin_low_oe),
      .pin_o            (reset_pin_low_o),
      .chip_reset       (chip_reset),
      .reset_vector_req (reset_vector_req)
   );

endmodule : port_pin_ctrl

// [rtl/port_pkg.sv]
// Package holding register map, field layouts and reset values of the port pin block
package port_pkg;

   // Register byte addresses (word aligned)
   localparam logic [7:0] P0_DIR_ADDR     = 8'h00;
   localparam logic [7:0] P0_PULL_ADDR    = 8'h04;
   localparam logic [7:0] POL_SEL_ADDR    = 8'h08;
   localparam logic [7:0] P2_DIR_ADDR     = 8'h0c;
   localparam logic [7:0] P2_PULL_ADDR    = 8'h10;
   localparam logic [7:0] P8_DIR_ADDR     = 8'h14;
   localparam logic [7:0] P8_PULL_ADDR    = 8'h18;
   localparam logic [7:0] PA_DIR_ADDR     = 8'h1c;
   localparam logic [7:0] PA_PULL_ADDR    = 8'h20;
   localparam logic [7:0] P0_OUT_ADDR     = 8'h24;
   localparam logic [7:0] P2_OUT_ADDR     = 8'h28;
   localparam logic [7:0] P8_OUT_ADDR     = 8'h2c;
   localparam logic [7:0] PA_OUT_ADDR     = 8'h30;
   localparam logic [7:0] ALT_SEL_ADDR    = 8'h34;
   localparam logic [7:0] P0_IN_ADDR      = 8'h38;
   localparam logic [7:0] P2_IN_ADDR      = 8'h3c;
   localparam logic [7:0] P8_IN_ADDR      = 8'h40;
   localparam logic [7:0] PA_IN_ADDR      = 8'h44;
   localparam logic [7:0] RST_CTRL_ADDR   = 8'h48;
   localparam logic [7:0] RST_STAT_ADDR   = 8'h4c;

   // Port widths
   localparam int P0_W = 6;
   localparam int P2_W = 7;
   localparam int P8_W = 6;
   localparam int PA_W = 8;

   // Pull polarity select field positions
   localparam int POL_P0_BIT = 0;
   localparam int POL_PA_BIT = 1;
   // Alternate function select field positions
   localparam int ALT_P8_BIT = 0;
   localparam int ALT_PA_BIT = 1;
   // Reset status field positions
   localparam int STAT_AUTO_BIT = 0;
   localparam int STAT_PIN_BIT  = 1;

   // Reset values: input, pull off
   localparam logic [7:0]  DIR_RST    = 8'h00;
   localparam logic [7:0]  PULL_RST   = 8'h00;
   localparam logic [7:0]  OUT_RST    = 8'h00;
   localparam logic [1:0]  POL_RST    = 2'h0;
   localparam logic [1:0]  ALT_RST    = 2'h0;
   localparam logic [31:0] UNMAP_DATA = 32'h0000_0000;

   // Clock settle time after reset pin release
   localparam int CLK_FREQ_HZ    = 20_000_000;
   localparam int SETTLE_US      = 100;
   localparam int SETTLE_CYCLES  = (SETTLE_US * (CLK_FREQ_HZ / 1_000_000));
   // Software reset pulse length on the pin
   localparam int SWRST_NS       = 1000;
   localparam int SWRST_CYCLES   = (SWRST_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] pull_en;
      logic       pull_up;
      logic       pull_down;
   } pin_cfg_s;

   typedef struct packed {
      logic [P0_W-1:0] oe;
      logic [P0_W-1:0] o;
      logic [P0_W-1:0] pu;
      logic [P0_W-1:0] pd;
   } p0_pins_s;

   typedef struct packed {
      logic [P2_W-1:0] oe;
      logic [P2_W-1:0] o;
      logic [P2_W-1:0] pu;
   } p2_pins_s;

   typedef struct packed {
      logic [P8_W-1:0] oe;
      logic [P8_W-1:0] o;
      logic [P8_W-1:0] pu;
   } p8_pins_s;

   typedef struct packed {
      logic [PA_W-1:0] oe;
      logic [PA_W-1:0] o;
      logic [PA_W-1:0] pu;
      logic [PA_W-1:0] pd;
   } pa_pins_s;

endpackage : port_pkg

// [rtl/reset_pin_ctrl.sv]
// Reset pin sequencer: pin release, clock settle wait, software reset drive
`timescale 1ns/100ps
module reset_pin_ctrl
   import port_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic rst_n_sync,
   input  wire logic pin_level,
   input  wire logic sw_reset,
   output logic      pin_oe,
   output logic      pin_o,
   output logic      chip_reset,
   output logic      reset_vector_req
);

   typedef enum logic [1:0] {ST_HELD, ST_SETTLE, ST_RUN, ST_SWDRIVE} rst_state_e;

   rst_state_e  state_q, state_d;
   logic [31:0] cnt_q, cnt_d;
   logic        req_q, req_d;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      req_d   = 1'b0;
      case (state_q)
         ST_HELD: begin
            cnt_d = 32'h0000_0000;
            if (pin_level) begin
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            // Wait for clock to settle before vectoring
            if (!pin_level) begin
               state_d = ST_HELD;
            end else if (cnt_q >= 32'(SETTLE - 1)) begin
               state_d = ST_RUN;
               req_d   = 1'b1;
            end else begin
               cnt_d = cnt_q + 32'h0000_0001;
            end
         end
         ST_RUN: begin
            cnt_d = 32'h0000_0000;
            if (sw_reset) begin
               state_d = ST_SWDRIVE;
            end else if (!pin_level) begin
               state_d = ST_HELD;
            end
         end
         ST_SWDRIVE: begin
            // Hold the pin low long enough for outside parts to see it
            if (cnt_q >= 32'(SWRST_CYCLES - 1)) begin
               state_d = ST_HELD;
            end else begin
               cnt_d = cnt_q + 32'h0000_0001;
            end
         end
         default: begin
            state_d = ST_HELD;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         state_q <= ST_HELD;
         cnt_q   <= 32'h0000_0000;
         req_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         req_q   <= req_d;
      end
   end

   // Open drain: only ever pulls low, never drives high
   assign pin_oe           = (state_q == ST_SWDRIVE);
   assign pin_o            = 1'b0;
   assign chip_reset       = (state_q != ST_RUN);
   assign reset_vector_req = req_q;

endmodule : reset_pin_ctrl

// [tb/port_pin_ctrl_asserts.sv]
// Concurrent checks on the port pin block ports
`timescale 1ns/100ps
module port_pin_ctrl_asserts
   import port_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYCLES
) (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire p0_pins_s    p0_pins,
   input wire p2_pins_s    p2_pins,
   input wire pa_pins_s    pa_pins,
   input wire logic        reset_pin_low_i,
   input wire logic        reset_pin_low_o,
   input wire logic        reset_pin_low_oe,
   input wire logic        chip_reset,
   input wire logic        reset_vector_req
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   a_dir_write: assert property (wb_ack_o && wb_cyc_i && wb_we_i && wb_sel_i[0] && wb_adr_i == P0_DIR_ADDR
      |=> p0_pins.oe == $past(wb_dat_i[P0_W-1:0])) else $error("port 0 enables differ from written direction");
   a_p0_pull_excl: assert property (!(|p0_pins.pu && |p0_pins.pd))
      else $error("port 0 mixes pull up and down");
   a_pa_pull_excl: assert property (!(|pa_pins.pu && |pa_pins.pd))
      else $error("port A mixes pull up and down");
   a_p2_pull_input: assert property ((p2_pins.pu & p2_pins.oe) == '0)
      else $error("port 2 pull on a driven pin");
   // Internal reset still holds for two edges after release
   a_reset_defaults: assert property ($rose(resetn) |-> chip_reset &&
      {p0_pins.oe, p0_pins.pu, p0_pins.pd, p2_pins.oe, p2_pins.pu, pa_pins.oe, pa_pins.pu, pa_pins.pd} == '0)
      else $error("pins not idle after reset");
   a_pin_reset: assert property (!reset_pin_low_i |-> ##[1:4] chip_reset)
      else $error("low reset pin did not reset chip");
   a_vector_clear: assert property (reset_vector_req |-> ##[0:1] !chip_reset)
      else $error("chip reset held after reset vector");
   a_swrst_len: assert property ($rose(reset_pin_low_oe) |->
      reset_pin_low_oe[*8] ##12 reset_pin_low_oe ##1 !reset_pin_low_oe) else $error("software reset pulse length");
   a_pin_never_high: assert property (reset_pin_low_oe |-> reset_pin_low_o == 1'b0)
      else $error("reset pin driven high");
   c_read: cover property (wb_ack_o && !wb_we_i);
   c_swrst: cover property ($rose(reset_pin_low_oe));
   c_vector: cover property (reset_vector_req);
endmodule : port_pin_ctrl_asserts

bind port_pin_ctrl port_pin_ctrl_asserts #(.SETTLE(SETTLE)) u_asserts (.*);

// [tb/port_pin_ctrl_test.sv]
// Self-checking bench for the port pin block
`timescale 1ns/100ps
module port_pin_ctrl_test
   import port_pkg::*;
;
   localparam int SET = 8;
   localparam logic [7:0] WA[14] = '{P0_DIR_ADDR, P0_PULL_ADDR, POL_SEL_ADDR, P2_DIR_ADDR, P2_PULL_ADDR,
      P8_DIR_ADDR, P8_PULL_ADDR, PA_DIR_ADDR, PA_PULL_ADDR, P0_OUT_ADDR, P2_OUT_ADDR, P8_OUT_ADDR,
      PA_OUT_ADDR, ALT_SEL_ADDR};
   localparam logic [7:0] MK[14] = '{8'h3f, 8'h3f, 8'h03, 8'h7f, 8'h7f, 8'h3f, 8'h3f, 8'hff, 8'hff,
      8'h3f, 8'h7f, 8'h3f, 8'hff, 8'h03};
   logic        ref_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pin_drv, fast_osc_en, fast_osc_in;
   logic        reset_pin_low_o, reset_pin_low_oe, auto_reset_strap, auto_reset_en, chip_reset;
   logic        reset_vector_req;
   logic [7:0]  wb_adr_i, pa_i, porta_alt_o, porta_alt_oe;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, pl;
   logic [5:0]  p0_i, p8_i, motor_timer_output;
   logic [6:0]  p2_i;
   p0_pins_s    p0_pins;
   p2_pins_s    p2_pins;
   p8_pins_s    p8_pins;
   pa_pins_s    pa_pins;
   logic [31:0] q[$];
   logic [31:0] v[14];
   logic [31:0] m[14];
   int          failures = 0;
   int          num_checks = 0;
   int          oe_cnt = 0;
   int          cyc_n = 0;
   // Pin model: follows pin_drv unless the block pulls it low
   wire logic   reset_pin_low_i = reset_pin_low_oe ? 1'b0 : pin_drv;

   port_pin_ctrl #(.SETTLE(SET)) DUT (.*);

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize;
      if (failures == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize

   // Expected read data goes to the queue; the monitor compares it on ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'h1;
      if (!we) q.push_back(d);
      @(posedge ref_clk);
      while (wb_ack_o !== 1'b1) @(posedge ref_clk);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge ref_clk);
   endtask : wb

   task automatic wait_vec;
      int n;
      n = 0;
      while (reset_vector_req !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(n inside {[SET:SET+8]}), 32'h1);
      @(posedge ref_clk);
      chk(32'(chip_reset), 32'h0);
   endtask : wait_vec

   task automatic do_reset(input logic strap);
      resetn <= 1'b0;
      auto_reset_strap <= strap;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      wait_vec();
      chk(32'(|{p0_pins, p2_pins, p8_pins, pa_pins}), 32'h0);
      chk(32'(auto_reset_en), 32'(strap));
      wb(1'b0, RST_STAT_ADDR, {30'h0, 1'b1, strap});
      wb(1'b0, PA_DIR_ADDR, 32'h0);
   endtask : do_reset

   always @(posedge ref_clk) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         failures++;
         summarize();
      end else begin
         if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0) chk(wb_dat_o, q.pop_front());
         if (reset_pin_low_oe === 1'b1) oe_cnt++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {resetn, wb_cyc_i, wb_stb_i, wb_we_i, fast_osc_en, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {p0_i, p2_i, p8_i, pa_i, motor_timer_output, porta_alt_o, porta_alt_oe} = '0;
      pin_drv = 1'b1;
      auto_reset_strap = 1'b1;
      void'($urandom(5086));
      do_reset(1'b1);
      for (int i = 0; i < 20; i++) begin
         p0_i <= 6'($urandom);
         p2_i <= 7'($urandom);
         p8_i <= 6'($urandom);
         pa_i <= 8'($urandom);
         motor_timer_output <= 6'($urandom);
         porta_alt_o <= 8'($urandom);
         porta_alt_oe <= 8'($urandom);
         fast_osc_en <= 1'($urandom);
         for (int k = 0; k < 14; k++) begin
            v[k] = $urandom;
            m[k] = v[k] & 32'(MK[k]);
            wb(1'b1, WA[k], v[k]);
         end
         for (int k = 0; k < 14; k++) wb(1'b0, WA[k], m[k]);
         chk(32'(p0_pins.oe), m[0]);
         chk(32'(p0_pins.o), m[9]);
         pl = m[1] & ~m[0] & 32'h3f;
         chk(32'({p0_pins.pd, p0_pins.pu}), m[2][0] ? pl << 6 : pl);
         pl = fast_osc_en ? 32'h1f : 32'h7f;
         chk(32'({p2_pins.oe, p2_pins.o}), {m[3][24:0] & pl[24:0], m[10][6:0]});
         chk(32'(p2_pins.pu), m[4] & ~m[3] & pl);
         chk(32'(p8_pins.oe), m[5]);
         chk(32'(p8_pins.pu), m[6] & ~m[5] & 32'h3f);
         chk(32'(p8_pins.o), m[13][0] ? 32'(motor_timer_output) : m[11]);
         chk(32'(pa_pins.oe), m[13][1] ? 32'(porta_alt_oe) : m[7]);
         chk(32'(pa_pins.o), m[13][1] ? 32'(porta_alt_o) : m[12]);
         pl = m[8] & ~(m[13][1] ? 32'(porta_alt_oe) : m[7]) & 32'hff;
         chk(32'({pa_pins.pd, pa_pins.pu}), m[2][1] ? pl << 8 : pl);
         chk(32'(fast_osc_in), 32'(p2_i[5]));
         wb(1'b0, P0_IN_ADDR, 32'(p0_i));
         wb(1'b0, P2_IN_ADDR, 32'(p2_i));
         wb(1'b0, P8_IN_ADDR, 32'(p8_i));
         wb(1'b0, PA_IN_ADDR, 32'(pa_i));
      end
      // Unmapped place: write dropped, read zero
      wb(1'b1, 8'h50, 32'hff);
      wb(1'b0, 8'h50, UNMAP_DATA);
      wb(1'b0, P0_DIR_ADDR, m[0]);
      pin_drv <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk(32'(chip_reset), 32'h1);
      pin_drv <= 1'b1;
      wait_vec();
      // Writing one must not start a software reset
      wb(1'b1, RST_CTRL_ADDR, 32'h1);
      repeat (4) @(posedge ref_clk);
      chk(32'(oe_cnt), 32'h0);
      wb(1'b0, RST_CTRL_ADDR, 32'h1);
      wb(1'b1, RST_CTRL_ADDR, 32'h0);
      chk(32'({reset_pin_low_oe, reset_pin_low_o}), 32'h2);
      while (reset_pin_low_oe !== 1'b0 || oe_cnt == 0) @(posedge ref_clk);
      chk(32'(oe_cnt), 32'(SWRST_CYCLES));
      wait_vec();
      do_reset(1'b0);
      chk(32'(q.size()), 32'h0);
      summarize();
   end
endmodule : port_pin_ctrl_test
